// ===== design/input_status_regs.vh
// Register offsets, field positions and reset values of the status bank.
`ifndef INPUT_STATUS_REGS_VH
`define INPUT_STATUS_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (7-bit register address)
// ----------------------------------------------------------------------
`define ADDR_INPUT_LEVELS    7'h48
`define ADDR_OVERLOAD_FLAGS  7'h54
`define ADDR_OPEN_LOAD_FLAGS 7'h55

// ----------------------------------------------------------------------
// Field positions of the input level register
// ----------------------------------------------------------------------
`define LVL_DEV_MODE_BIT     7
`define LVL_PULLUP_BIT       6
`define LVL_GPIO2_BIT        5
`define LVL_GPIO1_BIT        4
`define LVL_RSVD_BIT         3
`define LVL_WAKE_MSB         2
`define LVL_WAKE_LSB         0

// ----------------------------------------------------------------------
// Switch fault registers: flags in [3:0], reserved in [7:4]
// ----------------------------------------------------------------------
`define FLT_FLAG_MSB         3
`define FLT_FLAG_LSB         0
`define FLT_RSVD_MSB         7
`define FLT_RSVD_LSB         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_FLAGS            4'h0
`define RST_WAKE_LEVELS      3'h0
`define RST_GPIO_LEVELS      2'h0
`define RST_RDATA            8'h00
`define RST_SYNC             1'h0
`define RST_RVALID           1'h0

`endif

// ===== design/level_sync.v
// Two-flop synchroniser for a group of asynchronous pin levels.
`include "input_status_regs.vh"

module level_sync
#(
  parameter WIDTH = 1
)
(
  // Clock and reset
  input  wire             ref_clk_in,
  input  wire             reset_in,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      meta_r   <= {WIDTH{`RST_SYNC}};
      sync_out <= {WIDTH{`RST_SYNC}};
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== design/input_level_and_switch_fault_status.v
// Input level register and latched high-side switch fault flags.
//
// What this block does
// - Level bit 7 reads 1 in development mode at the test pin, else 0.
// - Level bit 6 reads 1 with external pull-up on interrupt pin.
// - Bits 5:4 show general pins 2,1; bits 2:0 show wake inputs 3..1.
// - Level bit 3 and fault bits 7:4 always read zero.
// - General pin levels refresh in normal/stop when wake or switch use.
// - Cyclic sense: wake level bits hold last sample, rewritten each sample.
// - General pins never use cyclic sampling; only wake inputs do.
// - Selected as general I/O, pin level shows even in switch use.
// - Per switch, overcurrent/overtemperature latches flag bit 3..0.
// - Per switch, open load latches flag bit 3..0.
`include "input_status_regs.vh"

module input_level_and_switch_fault_status
(
  // Clock and reset
  input  wire       ref_clk_in,
  input  wire       reset_in,
  input  wire       restart_in,
  // Register read port from the serial interface decoder
  input  wire [6:0] reg_addr_in,
  input  wire       reg_rd_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  // Asynchronous pin levels
  input  wire [2:0] wake_pin_in,
  input  wire [1:0] general_pin_in,
  input  wire       fail_output_test_pin_in,
  input  wire       int_pullup_sense_in,
  // Mode and pin configuration from on-chip control logic
  input  wire       active_mode_in,
  input  wire       cyclic_sense_in,
  input  wire       sample_strobe_in,
  input  wire [1:0] general_io_select_in,
  input  wire [1:0] wake_or_switch_cfg_in,
  // Fault detector events, one bit per switch 4..1
  input  wire [3:0] overload_event_in,
  input  wire [3:0] open_load_event_in
);

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Every pin level whose capture is enabled reaches its register bit three edges
  wire [2:0] wake_sync;
  wire [1:0] general_sync;
  wire [1:0] strap_sync;

  level_sync #(.WIDTH(3)) u_wake_sync
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (wake_pin_in),
    .sync_out   (wake_sync)
  );

  level_sync #(.WIDTH(2)) u_general_sync
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   (general_pin_in),
    .sync_out   (general_sync)
  );

  level_sync #(.WIDTH(2)) u_strap_sync
  (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .async_in   ({fail_output_test_pin_in, int_pullup_sense_in}),
    .sync_out   (strap_sync)
  );

  // --------------------------------------------------------------------
  // Level capture
  // --------------------------------------------------------------------
  reg  [2:0] wake_level_r;
  reg  [1:0] general_level_r;
  reg        development_mode_level_r;
  reg        int_pullup_config_sense_r;
  wire       wake_update;
  wire [1:0] general_update;

  // In cyclic sense the wake bits only move on a sampling event, so
  // software sees exactly the value the sampler judged.
  assign wake_update = cyclic_sense_in ? sample_strobe_in : 1'h1;

  // The sample strobe plays no part here: these pins are not sampled.
  assign general_update = {2{active_mode_in}} &
                          (general_io_select_in |
                           wake_or_switch_cfg_in);

  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      wake_level_r              <= `RST_WAKE_LEVELS;
      general_level_r           <= `RST_GPIO_LEVELS;
      development_mode_level_r  <= `RST_SYNC;
      int_pullup_config_sense_r <= `RST_SYNC;
    end
    else
    begin
      development_mode_level_r  <= strap_sync[1];
      int_pullup_config_sense_r <= strap_sync[0];
      if (wake_update)
      begin
        wake_level_r <= wake_sync;
      end
      if (general_update[0])
      begin
        general_level_r[0] <= general_sync[0];
      end
      if (general_update[1])
      begin
        general_level_r[1] <= general_sync[1];
      end
    end
  end

  // --------------------------------------------------------------------
  // Latched switch fault flags
  // --------------------------------------------------------------------
  reg  [3:0] overload_flags_r;
  reg  [3:0] overload_flags_nxt;
  reg  [3:0] open_load_flags_r;
  reg  [3:0] open_load_flags_nxt;
  wire       rd_overload;
  wire       rd_open_load;

  // Apart from reset, a taken read of a fault address is the only thing that clears it.
  assign rd_overload  = reg_rd_in && (reg_addr_in == `ADDR_OVERLOAD_FLAGS);
  assign rd_open_load = reg_rd_in && (reg_addr_in == `ADDR_OPEN_LOAD_FLAGS);

  // The event term is OR-ed after the clear, so a fault arriving in the
  // read cycle survives and is reported by the next read.
  always @*
  begin
    overload_flags_nxt  = rd_overload ? `RST_FLAGS : overload_flags_r;
    overload_flags_nxt  = overload_flags_nxt | overload_event_in;
    open_load_flags_nxt = rd_open_load ? `RST_FLAGS : open_load_flags_r;
    open_load_flags_nxt = open_load_flags_nxt | open_load_event_in;
  end

  // A restart keeps the flags; reset, or a read taken in restart with its answer not valid, clears them unread.
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      overload_flags_r  <= `RST_FLAGS;
      open_load_flags_r <= `RST_FLAGS;
    end
    else
    begin
      overload_flags_r  <= overload_flags_nxt;
      open_load_flags_r <= open_load_flags_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  reg [7:0] rdata_nxt;

  always @*
  begin
    rdata_nxt = 8'h00;
    case (reg_addr_in)
      `ADDR_INPUT_LEVELS:
      begin
        rdata_nxt[`LVL_DEV_MODE_BIT] = development_mode_level_r;
        rdata_nxt[`LVL_PULLUP_BIT]   = int_pullup_config_sense_r;
        rdata_nxt[`LVL_GPIO2_BIT]    = general_level_r[1];
        rdata_nxt[`LVL_GPIO1_BIT]    = general_level_r[0];
        rdata_nxt[`LVL_RSVD_BIT]     = 1'h0;
        rdata_nxt[`LVL_WAKE_MSB:`LVL_WAKE_LSB] = wake_level_r;
      end
      `ADDR_OVERLOAD_FLAGS:
      begin
        rdata_nxt[`FLT_FLAG_MSB:`FLT_FLAG_LSB] = overload_flags_r;
        rdata_nxt[`FLT_RSVD_MSB:`FLT_RSVD_LSB] = 4'h0;
      end
      `ADDR_OPEN_LOAD_FLAGS:
      begin
        rdata_nxt[`FLT_FLAG_MSB:`FLT_FLAG_LSB] = open_load_flags_r;
        rdata_nxt[`FLT_RSVD_MSB:`FLT_RSVD_LSB] = 4'h0;
      end
      default:
      begin
        rdata_nxt = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Read answer
  // --------------------------------------------------------------------
  // Restart only holds the read answer valid low: no other state of this bank
  // changes on it, since every value here is either live or kept over restart.
  always @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out  <= `RST_RDATA;
      reg_rvalid_out <= `RST_RVALID;
    end
    else
    begin
      reg_rvalid_out <= reg_rd_in & ~restart_in;
      if (reg_rd_in)
      begin
        reg_rdata_out <= rdata_nxt;
      end
    end
  end

endmodule

// ===== dv/input_status_chk.sv
// Checker of read answers, reserved bits, fault flags and level bits.
module input_status_chk
(
  // Clock, reset and read port
  input wire logic       ref_clk_in,
  input wire logic       reset_in,
  input wire logic       restart_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       reg_rvalid_out,
  // Pins and fault events
  input wire logic       fail_output_test_pin_in,
  input wire logic       int_pullup_sense_in,
  input wire logic [3:0] overload_event_in,
  input wire logic [3:0] open_load_event_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (reset_in);

  a_read_answered: assert property (
    reg_rvalid_out == $past(reg_rd_in && !restart_in)) else $error("rvalid");
  a_level_rsvd_zero: assert property (
    reg_rd_in && reg_addr_in == 7'h48 |=> !reg_rdata_out[3]) else $error("b3");
  a_fault_rsvd_zero: assert property (
    reg_rd_in && reg_addr_in[6:1] == 6'h2a |=> reg_rdata_out[7:4] == 4'h0)
    else $error("fault reserved bits");
  a_overload_flag_seen: assert property (
    reg_rd_in && reg_addr_in == 7'h54 |=> (reg_rdata_out[3:0]
    & $past(overload_event_in, 2)) == $past(overload_event_in, 2))
    else $error("overload flag lost");
  a_open_load_seen: assert property (
    reg_rd_in && reg_addr_in == 7'h55 |=> (reg_rdata_out[3:0]
    & $past(open_load_event_in, 2)) == $past(open_load_event_in, 2))
    else $error("open load flag lost");
  a_clear_on_read: assert property (
    (reg_rd_in && reg_addr_in == 7'h54 && overload_event_in == 4'h0) ##1
    (reg_rd_in && reg_addr_in == 7'h54) |=> reg_rdata_out[3:0] == 4'h0)
    else $error("flags not cleared");
  a_dev_mode_level: assert property (
    $stable(fail_output_test_pin_in)[*4] ##0 reg_rd_in && reg_addr_in == 7'h48
    |=> reg_rdata_out[7] == $past(fail_output_test_pin_in)) else $error("b7");
  a_pullup_level: assert property (
    $stable(int_pullup_sense_in)[*4] ##0 reg_rd_in && reg_addr_in == 7'h48
    |=> reg_rdata_out[6] == $past(int_pullup_sense_in)) else $error("b6");
endmodule

// ===== dv/host_model.sv
// Host model that issues register reads and collects each answer.
module host_model
(
  input  wire logic       ref_clk_in,
  output logic            reg_rd_out,
  output logic [6:0]      reg_addr_out,
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic       reg_rvalid_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    reg_rd_out = 1'h0;
    reg_addr_out = 7'h7f;
  end
  // A read also acknowledges the flags; back-to-back reads keep the strobe up.
  task automatic rd_reg(input logic [6:0] a, input bit last,
                        output logic [7:0] d, output logic v);
    reg_rd_out = 1'h1;
    reg_addr_out = a;
    @(posedge ref_clk_in);
    #1;
    d = reg_rdata_in;
    v = reg_rvalid_in;
    if (last)
    begin
      reg_rd_out = 1'h0;
      reg_addr_out = ~a;
    end
  endtask
endmodule

// ===== dv/input_level_and_switch_fault_status_bench.sv
// Bench for the input level and switch fault status registers.
module input_level_and_switch_fault_status_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 0, reset_in = 1, restart_in = 0, reg_rd_in;
  logic fail_output_test_pin_in = 0, int_pullup_sense_in = 0;
  logic active_mode_in = 0, cyclic_sense_in = 0, sample_strobe_in = 0;
  logic [6:0] reg_addr_in;
  logic [7:0] reg_rdata_out;
  logic reg_rvalid_out;
  logic [2:0] wake_pin_in = 0;
  logic [1:0] general_pin_in = 0, general_io_select_in = 0;
  logic [1:0] wake_or_switch_cfg_in = 0;
  logic [3:0] overload_event_in = 0, open_load_event_in = 0;
  int miscompares = 0, samples_checked = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;
  input_level_and_switch_fault_status dut (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .restart_in(restart_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .wake_pin_in(wake_pin_in), .general_pin_in(general_pin_in),
    .fail_output_test_pin_in(fail_output_test_pin_in),
    .int_pullup_sense_in(int_pullup_sense_in),
    .active_mode_in(active_mode_in), .cyclic_sense_in(cyclic_sense_in),
    .sample_strobe_in(sample_strobe_in),
    .general_io_select_in(general_io_select_in),
    .wake_or_switch_cfg_in(wake_or_switch_cfg_in),
    .overload_event_in(overload_event_in),
    .open_load_event_in(open_load_event_in));
  host_model host (.ref_clk_in(ref_clk_in), .reg_rd_out(reg_rd_in),
    .reg_addr_out(reg_addr_in), .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out));

  task tick(int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task rdx(logic [6:0] a, bit last, logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd_reg(a, last, d, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk("rdata", e, d);
  endtask
  task test_levels;
    fail_output_test_pin_in = 1;
    int_pullup_sense_in = 1;
    wake_pin_in = 3'h5;
    general_pin_in = 2'h2;
    active_mode_in = 1;
    general_io_select_in = 2'h3;
    tick(4);
    rdx(7'h48, 1, 8'he5);
    general_io_select_in = 2'h0;
    wake_or_switch_cfg_in = 2'h1;
    general_pin_in = 2'h1;
    tick(4);
    rdx(7'h48, 1, 8'hf5);
    general_io_select_in = 2'h1;
    general_pin_in = 2'h0;
    tick(4);
    rdx(7'h48, 1, 8'he5);
    $display("levels done");
  endtask
  task test_cyclic;
    cyclic_sense_in = 1;
    wake_pin_in = 3'h2;
    general_pin_in = 2'h1;
    tick(4);
    rdx(7'h48, 1, 8'hf5);
    sample_strobe_in = 1;
    tick(1);
    sample_strobe_in = 0;
    tick(1);
    rdx(7'h48, 1, 8'hf2);
    $display("cyclic done");
  endtask
  task test_faults;
    for (int i = 0; i < 2; i++)
    begin
      if (i == 0) overload_event_in = 4'ha;
      else open_load_event_in = 4'h5;
      tick(1);
      overload_event_in = 0;
      open_load_event_in = 0;
      rdx(7'h54 + 7'(i), 0, i ? 8'h05 : 8'h0a);
      rdx(7'h54 + 7'(i), 1, 8'h00);
    end
    tick(1);
    overload_event_in = 4'h1;
    rdx(7'h54, 0, 8'h00);
    overload_event_in = 0;
    rdx(7'h54, 1, 8'h01);
    $display("faults done");
  endtask
  task test_restart;
    logic [7:0] d;
    logic v;
    overload_event_in = 4'h8;
    tick(1);
    overload_event_in = 0;
    restart_in = 1;
    host.rd_reg(7'h54, 1, d, v);
    restart_in = 0;
    chk("rvalid in restart", 8'h00, {7'h00, v});
    chk("flags in restart", 8'h08, d);
    tick(1);
    rdx(7'h54, 1, 8'h00);
    $display("restart done");
  endtask
  task results;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    tick(6);
    reset_in = 0;
    tick(3);
    test_levels;
    test_cyclic;
    test_faults;
    test_restart;
    results;
  end
  initial
  begin
    #50000;
    miscompares++;
    results;
  end
endmodule

bind input_level_and_switch_fault_status input_status_chk chk_i (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .restart_in(restart_in),
  .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .fail_output_test_pin_in(fail_output_test_pin_in),
  .int_pullup_sense_in(int_pullup_sense_in),
  .overload_event_in(overload_event_in),
  .open_load_event_in(open_load_event_in));
